// [logic/imacc_top.sv]
// two-wire master: address, read count and clock divider registers
// assumes axi4-lite master on the bus side, pull-ups on scl and sda
// Contract
// RQ1 - software loads read count minus one
// RQ2 - software sets extend bit above 256 bytes
// RQ3 - read-only count of bytes received
// RQ4 - first address register forms address byte
// RQ5 - seven-bit address from bits 7 to 1
// RQ6 - bit 0 picks read or write
// RQ7 - software writes 11110 for ten-bit mode
// RQ8 - bits 2 and 1 carry address 9:8
// RQ9 - second register carries address 7:0
// RQ10 - second register used only in ten-bit
// RQ11 - upper divider byte sets scl high
// RQ12 - lower divider byte sets scl low
// RQ13 - slave transmit interrupt when enabled
// RQ14 - ack all but last byte read
// RQ15 - ten-bit: two bytes, restart to read
`timescale 1ns/1ps
module imacc_top
  import imacc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        sclIn,
  output logic             sclOut,
  output logic             sclOe,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOe,
  input  wire logic        slaveTxByteDone,
  output logic             slaveTxIrq
);

  // ****************
  // functions
  // ****************
  function automatic imacc_reg_t imacc_decode(input logic [31:0] a);
    if (a == ADDR_READ_COUNT) return REG_READ_COUNT;
    else if (a == ADDR_RECV_COUNT) return REG_RECV_COUNT;
    else if (a == ADDR_SLV_FIRST) return REG_SLV_FIRST;
    else if (a == ADDR_SLV_LOW) return REG_SLV_LOW;
    else if (a == ADDR_CLK_DIV) return REG_CLK_DIV;
    else if (a == ADDR_SLV_CTRL) return REG_SLV_CTRL;
    else if (a == ADDR_MST_CTRL) return REG_MST_CTRL;
    else if (a == ADDR_MST_STAT) return REG_MST_STAT;
    else return REG_NONE;
  endfunction : imacc_decode

  // byte lanes 0 and 1 only; upper lanes hold nothing
  function automatic logic [15:0] imacc_merge(input logic [15:0] old,
                                              input logic [31:0] d,
                                              input logic [3:0]  s,
                                              input logic [15:0] m);
    logic [15:0] v;
    v = old;
    if (s[0]) begin
      v[7:0] = d[7:0];
    end
    if (s[1]) begin
      v[15:8] = d[15:8];
    end
    return v & m;
  endfunction : imacc_merge

  // ****************
  // declarations
  // ****************
  logic [15:0]  readCount_ff;
  logic [7:0]   slvFirst_ff;
  logic [7:0]   slvLow_ff;
  imacc_div_t   clkDiv_ff;
  logic [15:0]  slvCtrl_ff;
  logic [15:0]  mstCtrl_ff;
  logic         startReq_ff;
  logic         awready_ff;
  logic         wready_ff;
  logic         bvalid_ff;
  logic [1:0]   bresp_ff;
  logic         awHave_ff;
  logic         wHave_ff;
  logic [31:0]  awAddr_ff;
  logic [31:0]  wData_ff;
  logic [3:0]   wStrb_ff;
  logic         arready_ff;
  logic         rvalid_ff;
  logic [31:0]  rdata_ff;
  logic [1:0]   rresp_ff;
  imacc_state_t state_ff;
  imacc_seq_t   seq_ff;
  logic         sclHigh_ff;
  logic         sclOe_ff;
  logic         sdaPull_ff;
  logic         sdaOe_ff;
  logic [3:0]   bitCnt_ff;
  logic [7:0]   shift_ff;
  logic [8:0]   rxTotal_ff;
  logic [7:0]   rxByte_ff;
  logic         lastRx_ff;
  logic         busy_ff;
  logic         nack_ff;
  logic         done_ff;
  logic         loadReq_ff;
  logic [7:0]   loadVal_ff;
  logic         slaveTxIrq_ff;
  logic         timerExpired;
  logic         phaseEnd;
  logic         writeFire;
  imacc_reg_t   wrReg;
  imacc_reg_t   rdReg;
  logic [31:0]  nxt_rdata;
  logic [7:0]   firstByte;
  imacc_addr_t  addrFirst;
  logic         tenBitMode;
  logic [7:0]   txByte;

  assign addrFirst  = imacc_addr_t'(slvFirst_ff);
  assign tenBitMode = mstCtrl_ff[CTRL_TEN_BIT];
  assign txByte     = mstCtrl_ff[15:8];
  // RQ4 address byte from first register
  // RQ8 ten-bit high bits pass as written
  assign firstByte  = tenBitMode ? {slvFirst_ff[7:1], 1'b0} : slvFirst_ff;
  assign writeFire  = awHave_ff && wHave_ff && !bvalid_ff;
  assign wrReg      = imacc_decode(awAddr_ff);
  assign rdReg      = imacc_decode(s_axi_araddr);
  // stale zero in the load cycle must not end the new phase
  assign phaseEnd   = timerExpired && !loadReq_ff;

  // ****************
  // phase timer
  // ****************
  // scl stretching: the high phase only counts while scl reads high
  imacc_phase_timer u_timer (
    .clk       (clk),
    .rst       (rst),
    .load      (loadReq_ff),
    .loadValue (loadVal_ff),
    .countEn   (!sclHigh_ff || sclIn),
    .expired   (timerExpired)
  );

  // ****************
  // axi4-lite write channel
  // ****************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      awready_ff <= 1'b1;
      wready_ff  <= 1'b1;
      awHave_ff  <= 1'b0;
      wHave_ff   <= 1'b0;
      awAddr_ff  <= 32'h0000_0000;
      wData_ff   <= 32'h0000_0000;
      wStrb_ff   <= 4'h0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && awready_ff) begin
        awAddr_ff  <= s_axi_awaddr;
        awHave_ff  <= 1'b1;
        awready_ff <= 1'b0;
      end
      if (s_axi_wvalid && wready_ff) begin
        wData_ff  <= s_axi_wdata;
        wStrb_ff  <= s_axi_wstrb;
        wHave_ff  <= 1'b1;
        wready_ff <= 1'b0;
      end
      if (writeFire) begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= (wrReg == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
      end
      if (bvalid_ff && s_axi_bready) begin
        bvalid_ff  <= 1'b0;
        awHave_ff  <= 1'b0;
        wHave_ff   <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff  <= 1'b1;
      end
    end
  end

  // ****************
  // register file
  // ****************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      readCount_ff <= RST_READ_COUNT;
      slvFirst_ff  <= RST_SLV_ADDR;
      slvLow_ff    <= RST_SLV_ADDR;
      clkDiv_ff    <= RST_CLK_DIV;
      slvCtrl_ff   <= RST_SLV_CTRL;
      mstCtrl_ff   <= RST_MST_CTRL;
      startReq_ff  <= 1'b0;
    end else begin
      if (state_ff == ST_IDLE) begin
        startReq_ff <= 1'b0;
      end
      if (writeFire) begin
        if (wrReg == REG_READ_COUNT) begin
          readCount_ff <= imacc_merge(readCount_ff, wData_ff, wStrb_ff,
                                      MASK_READ_COUNT);
        end else if (wrReg == REG_SLV_FIRST && wStrb_ff[0]) begin
          slvFirst_ff <= wData_ff[7:0];
        end else if (wrReg == REG_SLV_LOW && wStrb_ff[0]) begin
          slvLow_ff <= wData_ff[7:0];
        end else if (wrReg == REG_CLK_DIV) begin
          clkDiv_ff <= imacc_merge(clkDiv_ff, wData_ff, wStrb_ff,
                                   MASK_FULL);
        end else if (wrReg == REG_SLV_CTRL) begin
          slvCtrl_ff <= imacc_merge(slvCtrl_ff, wData_ff, wStrb_ff,
                                    MASK_SLV_CTRL);
        end else if (wrReg == REG_MST_CTRL) begin
          mstCtrl_ff <= imacc_merge(mstCtrl_ff, wData_ff, wStrb_ff,
                                    MASK_MST_CTRL);
          // a start while busy is dropped, not queued
          if (wStrb_ff[0] && wData_ff[CTRL_START_BIT] && !busy_ff) begin
            startReq_ff <= 1'b1;
          end
        end
      end
    end
  end

  // ****************
  // axi4-lite read channel
  // ****************
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (rdReg == REG_READ_COUNT) nxt_rdata[15:0] = readCount_ff;
    // RQ3 running received count
    else if (rdReg == REG_RECV_COUNT) nxt_rdata[7:0] = rxTotal_ff[7:0];
    else if (rdReg == REG_SLV_FIRST) nxt_rdata[7:0] = slvFirst_ff;
    else if (rdReg == REG_SLV_LOW) nxt_rdata[7:0] = slvLow_ff;
    else if (rdReg == REG_CLK_DIV) nxt_rdata[15:0] = clkDiv_ff;
    else if (rdReg == REG_SLV_CTRL) nxt_rdata[15:0] = slvCtrl_ff;
    else if (rdReg == REG_MST_CTRL) nxt_rdata[15:0] = mstCtrl_ff;
    else if (rdReg == REG_MST_STAT) begin
      nxt_rdata[STAT_BUSY_BIT] = busy_ff;
      nxt_rdata[STAT_NACK_BIT] = nack_ff;
      nxt_rdata[STAT_DONE_BIT] = done_ff;
      nxt_rdata[15:8]          = rxByte_ff;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      arready_ff <= 1'b1;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h0000_0000;
      rresp_ff   <= RESP_OKAY;
    end else if (s_axi_arvalid && arready_ff) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b1;
      rdata_ff   <= nxt_rdata;
      rresp_ff   <= (rdReg == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff  <= 1'b0;
      arready_ff <= 1'b1;
    end
  end

  // ****************
  // serial sequencer
  // ****************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff   <= ST_IDLE;
      seq_ff     <= SEQ_ADDR_FIRST;
      sclHigh_ff <= 1'b1;
      sclOe_ff   <= 1'b0;
      sdaPull_ff <= 1'b0;
      bitCnt_ff  <= 4'h0;
      shift_ff   <= 8'h00;
      rxTotal_ff <= 9'h000;
      rxByte_ff  <= RST_RECV_COUNT;
      lastRx_ff  <= 1'b0;
      busy_ff    <= 1'b0;
      nack_ff    <= 1'b0;
      done_ff    <= 1'b0;
      loadReq_ff <= 1'b0;
      loadVal_ff <= 8'h00;
    end else begin
      loadReq_ff <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          sclOe_ff   <= 1'b0;
          sdaPull_ff <= 1'b0;
          sclHigh_ff <= 1'b1;
          if (startReq_ff) begin
            busy_ff    <= 1'b1;
            nack_ff    <= 1'b0;
            done_ff    <= 1'b0;
            rxTotal_ff <= 9'h000;
            seq_ff     <= SEQ_ADDR_FIRST;
            // RQ5 RQ6 address and direction
            shift_ff   <= firstByte;
            sdaPull_ff <= 1'b1;
            state_ff   <= ST_START;
            loadReq_ff <= 1'b1;
            loadVal_ff <= clkDiv_ff.clockHighDivider;
          end
        end
        ST_START: begin
          if (phaseEnd) begin
            sclOe_ff   <= 1'b1;
            sclHigh_ff <= 1'b0;
            bitCnt_ff  <= 4'h0;
            sdaPull_ff <= ~shift_ff[7];
            state_ff   <= ST_TX;
            loadReq_ff <= 1'b1;
            loadVal_ff <= clkDiv_ff.clockLowDivider;
          end
        end
        ST_TX, ST_RX, ST_RSTART, ST_STOP: begin
          if (phaseEnd && !sclHigh_ff) begin
            // RQ11 high phase from upper byte
            sclOe_ff   <= 1'b0;
            sclHigh_ff <= 1'b1;
            loadReq_ff <= 1'b1;
            loadVal_ff <= clkDiv_ff.clockHighDivider;
          end else if (phaseEnd) begin
            // RQ12 low phase from lower byte
            sclOe_ff   <= 1'b1;
            sclHigh_ff <= 1'b0;
            loadReq_ff <= 1'b1;
            loadVal_ff <= clkDiv_ff.clockLowDivider;
            if (state_ff == ST_TX && bitCnt_ff != ACK_BIT) begin
              bitCnt_ff  <= bitCnt_ff + 4'h1;
              shift_ff   <= {shift_ff[6:0], 1'b0};
              sdaPull_ff <= ~shift_ff[6] && (bitCnt_ff != LAST_DATA_BIT);
            end else if (state_ff == ST_TX) begin
              bitCnt_ff <= 4'h0;
              if (sdaIn) begin
                nack_ff    <= 1'b1;
                sdaPull_ff <= 1'b1;
                state_ff   <= ST_STOP;
              end else begin
                case (seq_ff)
                  SEQ_ADDR_FIRST: begin
                    seq_ff <= SEQ_DATA;
                    if (tenBitMode) begin
                      // RQ9 RQ10 low byte only in ten-bit
                      seq_ff     <= SEQ_ADDR_LOW;
                      shift_ff   <= slvLow_ff;
                      sdaPull_ff <= ~slvLow_ff[7];
                    end else if (addrFirst.dir) begin
                      sdaPull_ff <= 1'b0;
                      state_ff   <= ST_RX;
                    end else begin
                      shift_ff   <= txByte;
                      sdaPull_ff <= ~txByte[7];
                    end
                  end
                  SEQ_ADDR_LOW: begin
                    if (addrFirst.dir) begin
                      // RQ15 repeated start turns to read
                      sdaPull_ff <= 1'b0;
                      state_ff   <= ST_RSTART;
                    end else begin
                      seq_ff     <= SEQ_DATA;
                      shift_ff   <= txByte;
                      sdaPull_ff <= ~txByte[7];
                    end
                  end
                  SEQ_ADDR_READ: begin
                    seq_ff     <= SEQ_DATA;
                    sdaPull_ff <= 1'b0;
                    state_ff   <= ST_RX;
                  end
                  default: begin
                    sdaPull_ff <= 1'b1;
                    state_ff   <= ST_STOP;
                  end
                endcase
              end
            end else if (state_ff == ST_RX && bitCnt_ff != ACK_BIT) begin
              bitCnt_ff  <= bitCnt_ff + 4'h1;
              shift_ff   <= {shift_ff[6:0], sdaIn};
              sdaPull_ff <= 1'b0;
              if (bitCnt_ff == LAST_DATA_BIT) begin
                rxTotal_ff <= rxTotal_ff + 9'h001;
                rxByte_ff  <= {shift_ff[6:0], sdaIn};
                // RQ14 no ack on the last byte
                lastRx_ff  <= (rxTotal_ff == readCount_ff[8:0]);
                sdaPull_ff <= (rxTotal_ff != readCount_ff[8:0]);
              end
            end else if (state_ff == ST_RX) begin
              bitCnt_ff  <= 4'h0;
              sdaPull_ff <= lastRx_ff;
              if (lastRx_ff) begin
                state_ff <= ST_STOP;
              end
            end else if (state_ff == ST_RSTART) begin
              // scl stays released through the start hold
              sclOe_ff   <= 1'b0;
              sclHigh_ff <= 1'b1;
              sdaPull_ff <= 1'b1;
              shift_ff   <= {slvFirst_ff[7:1], 1'b1};
              seq_ff     <= SEQ_ADDR_READ;
              state_ff   <= ST_START;
              loadVal_ff <= clkDiv_ff.clockHighDivider;
            end else begin
              sclOe_ff   <= 1'b0;
              sclHigh_ff <= 1'b1;
              sdaPull_ff <= 1'b0;
              busy_ff    <= 1'b0;
              done_ff    <= 1'b1;
              state_ff   <= ST_IDLE;
            end
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************
  // pin drivers and slave interrupt
  // ****************
  // sda trails the sequencer one clock so it moves after scl; at the start, repeated start and stop scl holds high while sda moves
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sdaOe_ff <= 1'b0;
    end else begin
      sdaOe_ff <= sdaPull_ff;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      slaveTxIrq_ff <= 1'b0;
    end else begin
      // RQ13 gated by the enable bit
      slaveTxIrq_ff <= slvCtrl_ff[SLV_TXIRQ_BIT] && slaveTxByteDone;
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready  = wready_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;
  // open drain: the pins are only ever pulled low
  assign sclOut        = 1'b0;
  assign sdaOut        = 1'b0;
  assign sclOe         = sclOe_ff;
  assign sdaOe         = sdaOe_ff;
  assign slaveTxIrq    = slaveTxIrq_ff;

endmodule : imacc_top

// [logic/imacc_pkg.sv]
// constants, types and register map of the two-wire master block
// assumes a 32-bit axi4-lite bus and one 40 MHz clock
package imacc_pkg;

  // ****************
  // register byte addresses
  // ****************
  localparam logic [31:0] ADDR_READ_COUNT = 32'hffff0890;
  localparam logic [31:0] ADDR_RECV_COUNT = 32'hffff0894;
  localparam logic [31:0] ADDR_SLV_FIRST  = 32'hffff0898;
  localparam logic [31:0] ADDR_SLV_LOW    = 32'hffff089c;
  localparam logic [31:0] ADDR_CLK_DIV    = 32'hffff08a4;
  localparam logic [31:0] ADDR_SLV_CTRL   = 32'hffff08a8;
  localparam logic [31:0] ADDR_MST_CTRL   = 32'hffff08e0;
  localparam logic [31:0] ADDR_MST_STAT   = 32'hffff08e4;

  // ****************
  // reset values and writable masks
  // ****************
  localparam logic [15:0] RST_READ_COUNT  = 16'h0000;
  localparam logic [7:0]  RST_RECV_COUNT  = 8'h00;
  localparam logic [7:0]  RST_SLV_ADDR    = 8'h00;
  localparam logic [15:0] RST_CLK_DIV     = 16'h1f1f;
  localparam logic [15:0] RST_SLV_CTRL    = 16'h0000;
  localparam logic [15:0] RST_MST_CTRL    = 16'h0000;
  localparam logic [15:0] MASK_READ_COUNT = 16'h01ff;
  localparam logic [15:0] MASK_SLV_ADDR   = 16'h00ff;
  localparam logic [15:0] MASK_FULL       = 16'hffff;
  localparam logic [15:0] MASK_SLV_CTRL   = 16'h07ff;
  localparam logic [15:0] MASK_MST_CTRL   = 16'hff02;

  // ****************
  // field positions
  // ****************
  localparam int READ_EXT_BIT   = 8;
  localparam int DIR_BIT        = 0;
  localparam int SLV_TXIRQ_BIT  = 10;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_TEN_BIT   = 1;
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_NACK_BIT  = 1;
  localparam int STAT_DONE_BIT  = 2;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] ACK_BIT       = 4'h8;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************
  // types
  // ****************
  typedef enum logic [3:0] {
    REG_NONE, REG_READ_COUNT, REG_RECV_COUNT, REG_SLV_FIRST,
    REG_SLV_LOW, REG_CLK_DIV, REG_SLV_CTRL, REG_MST_CTRL, REG_MST_STAT
  } imacc_reg_t;

  typedef enum logic [5:0] {
    ST_IDLE   = 6'h01,
    ST_START  = 6'h02,
    ST_TX     = 6'h04,
    ST_RX     = 6'h08,
    ST_RSTART = 6'h10,
    ST_STOP   = 6'h20
  } imacc_state_t;

  typedef enum logic [1:0] {
    SEQ_ADDR_FIRST, SEQ_ADDR_LOW, SEQ_ADDR_READ, SEQ_DATA
  } imacc_seq_t;

  typedef struct packed {
    logic [7:0] clockHighDivider;
    logic [7:0] clockLowDivider;
  } imacc_div_t;

  typedef struct packed {
    logic [6:0] sevenBitTargetAddress;
    logic       dir;
  } imacc_addr_t;

endpackage : imacc_pkg

// [logic/imacc_phase_timer.sv]
// down counter timing one half period of the serial clock
// assumes the caller loads it once per phase and waits for expired
`timescale 1ns/1ps
module imacc_phase_timer
  import imacc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       load,
  input  wire logic [7:0] loadValue,
  input  wire logic       countEn,
  output logic            expired
);

  logic [7:0] count_ff;

  // ****************
  // counter
  // ****************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_ff <= 8'h00;
    end else if (load) begin
      count_ff <= loadValue;
    end else if (countEn && (count_ff != 8'h00)) begin
      count_ff <= count_ff - 8'h01;
    end
  end

  assign expired = (count_ff == 8'h00);

endmodule : imacc_phase_timer

// [tb/imacc_props.sv]
// port checker for the two-wire master block
// assumes it is bound into imacc_top on its single clock
`timescale 1ns/1ps
module imacc_props
  import imacc_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        sclOe,
  input wire logic        slaveTxByteDone,
  input wire logic        slaveTxIrq
);
  // ****************
  // properties
  // ****************
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence sRdTaken; s_axi_arvalid && s_axi_arready; endsequence
  sequence sRdAns; s_axi_rvalid && !s_axi_arready; endsequence
  a_rd_answer: assert property (sRdTaken |=> sRdAns)
    else $error("read not answered");
  a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_w_refused: assert property (s_axi_bvalid |-> !s_axi_awready &&
    !s_axi_wready) else $error("write taken while answering");
  a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR
    |-> s_axi_rdata == 32'h0) else $error("error read not zero");
  a_irq_cause: assert property (slaveTxIrq |-> $past(slaveTxByteDone))
    else $error("irq without transmit");
  a_scl_low: assert property ($rose(sclOe) |-> sclOe [*3])
    else $error("scl low phase short");
  a_scl_high: assert property ($fell(sclOe) |-> !sclOe [*3])
    else $error("scl high phase short");
endmodule : imacc_props
bind imacc_top imacc_props u_props (.*);

// [tb/imacc_slave_model.sv]
// behavioural slave on the two-wire bus
// assumes pull-ups on both lines, resolved by the bench
`timescale 1ns/1ps
module imacc_slave_model (
  input wire logic scl,
  input wire logic sda,
  input wire logic stretch,
  output logic     sclLow,
  output logic     sdaLow
);
  logic [7:0] sh, tx, nByte;
  logic       rdMode, first;
  int         bitNo;
  logic [7:0] got[$];
  logic       ackSeen[$];
  initial begin
    {sclLow, sdaLow, rdMode, first, nByte, bitNo} = '0;
  end
  // start or repeated start restarts framing
  always @(negedge sda) if (scl) begin
    bitNo = 0;
    first = 1'h1;
    rdMode = 1'h0;
  end
  always @(posedge scl) begin
    if (bitNo < 8) sh = {sh[6:0], sda};
    else if (rdMode) begin
      ackSeen.push_back(!sda);
      // a nack ends our turn so the stop is not blocked
      rdMode = !sda;
    end
    bitNo++;
    if (bitNo == 8 && !rdMode) got.push_back(sh);
  end
  always @(negedge scl) begin
    if (bitNo == 9) begin
      bitNo = 0;
      rdMode = rdMode || (first && sh[0]);
      first = 1'h0;
      tx = 8'h96 ^ nByte;
      nByte++;
    end
    sdaLow = (bitNo == 8 && !rdMode) || (rdMode && bitNo < 8 && !tx[7-bitNo]);
    // slow answer: hold the clock low
    if (stretch) begin
      sclLow = 1'h1;
      #300 sclLow = 1'h0;
    end
  end
endmodule : imacc_slave_model

// [tb/i2c_master_addr_count_clock_test.sv]
// self-checking bench of the two-wire master block
// assumes checker and slave model are compiled before it
`timescale 1ns/1ps
module i2c_master_addr_count_clock_test
  import imacc_pkg::*;
;
  logic        clk = '0, rst = 1'h1, s_axi_awvalid = '0, s_axi_wvalid = '0;
  logic        s_axi_bready = '0, s_axi_arvalid = '0, s_axi_rready = '0;
  logic        slaveTxByteDone = '0, stretch = '0, prevOe = '0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, sclOut, sclOe, sdaOut, sdaOe, slaveTxIrq;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, v, seed = 32'hc736;
  logic        sclLow, sdaLow;
  wire         sclIn = !(sclOe || sclLow);
  wire         sdaIn = !(sdaOe || sdaLow);
  int          err_total = 0, num_checks = 0, run = 0, lowRun, hiRun;
  localparam logic [31:0] RA [6] = '{ADDR_READ_COUNT, ADDR_RECV_COUNT,
    ADDR_SLV_FIRST, ADDR_SLV_LOW, ADDR_CLK_DIV, ADDR_SLV_CTRL};
  localparam logic [15:0] RV [6] = '{RST_READ_COUNT, 16'(RST_RECV_COUNT),
    16'(RST_SLV_ADDR), 16'(RST_SLV_ADDR), RST_CLK_DIV, RST_SLV_CTRL};
  localparam logic [15:0] RM [6] = '{MASK_READ_COUNT, 16'h0,
    MASK_SLV_ADDR, MASK_SLV_ADDR, MASK_FULL, MASK_SLV_CTRL};
  imacc_top u_imacc_top (.*);
  imacc_slave_model u_slave (.scl(sclIn), .sda(sdaIn), .stretch(stretch),
    .sclLow(sclLow), .sdaLow(sdaLow));
  always #12.5 clk = !clk;
  // ****************
  // scl phase lengths
  // ****************
  always @(posedge clk) begin
    prevOe <= sclOe;
    if (sclOe == prevOe) run <= run + 1;
    else begin
      if (prevOe) lowRun <= run;
      else hiRun <= run;
      run <= 1;
    end
  end
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(string n, logic [31:0] got, logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", n, exp, got);
    end
  endtask : chk
  task automatic wr(logic [31:0] a, logic [31:0] d);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= seed[1];
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      s_axi_bready <= 1'h1;
    end while (!(s_axi_bvalid && s_axi_bready));
    rsp = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask : wr
  task automatic rd(logic [31:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= seed[0];
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      s_axi_rready <= 1'h1;
    end while (!(s_axi_rvalid && s_axi_rready));
    v = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask : rd
  task automatic xfer(logic [7:0] a0, a1, logic [8:0] cnt, logic ten, d);
    u_slave.got.delete();
    u_slave.ackSeen.delete();
    wr(ADDR_SLV_FIRST, {24'h0, a0});
    wr(ADDR_SLV_LOW, {24'h0, a1});
    wr(ADDR_READ_COUNT, {23'h0, cnt});
    wr(ADDR_MST_CTRL, {16'h0, d, 6'h0, ten, 1'h1});
    do rd(ADDR_MST_STAT);
    while (!v[STAT_DONE_BIT] || v[STAT_BUSY_BIT]);
  endtask : xfer
  task automatic rdx(logic [7:0] a0, a1, logic [8:0] cnt, logic ten);
    int n = cnt + 1;
    xfer(a0, a1, cnt, ten, 8'h0);
    chk("acks", u_slave.ackSeen.size(), n);
    for (int i = 0; i < n; i++)
      chk("ack", u_slave.ackSeen[i], i < n - 1);
    rd(ADDR_RECV_COUNT);
    chk("rxcnt", v, n % 256);
  endtask : rdx
  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim
  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    end_sim;
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    for (int i = 0; i < 6; i++) begin
      rd(RA[i]);
      chk("reset", v, RV[i]);
      seed = lfsr(seed);
      wr(RA[i], seed);
      rd(RA[i]);
      chk("rdback", v, seed & RM[i]);
    end
    wr(32'hffff08a0, seed);
    chk("wresp", rsp, RESP_SLVERR);
    rd(32'hffff08a0);
    chk("rresp", rsp, RESP_SLVERR);
    for (int e = 0; e < 2; e++) begin
      wr(ADDR_SLV_CTRL, {21'h0, e[0], 10'h0});
      slaveTxByteDone <= 1'h1;
      @(posedge clk);
      slaveTxByteDone <= 1'h0;
      #1;
      chk("irq", slaveTxIrq, e[0]);
    end
    seed = lfsr(seed);
    wr(ADDR_CLK_DIV, {16'h0, 8'h03, 5'h0, seed[2:0] | 3'h1});
    xfer({seed[15:9], 1'h0}, seed[23:16], 9'h0, 1'h0, seed[31:24]);
    chk("low", lowRun, (seed[2:0] | 3'h1) + 2);
    chk("high", hiRun, 32'h5);
    chk("addr", u_slave.got[0], {seed[15:9], 1'h0});
    chk("data", u_slave.got[1], seed[31:24]);
    wr(ADDR_CLK_DIV, 32'h0101);
    rdx({seed[6:0], 1'h1}, seed[15:8], 9'h101, 1'h0);
    stretch <= 1'h1;
    rdx({5'h1e, seed[1:0], 1'h1}, seed[15:8], 9'h0, 1'h1);
    chk("ten0", u_slave.got[0], {5'h1e, seed[1:0], 1'h0});
    chk("ten1", u_slave.got[1], seed[15:8]);
    chk("ten2", u_slave.got[2], {5'h1e, seed[1:0], 1'h1});
    end_sim;
  end
endmodule : i2c_master_addr_count_clock_test
